// file: link_carrier_if.sv
`timescale 1ns/1ns

interface link_carrier_if;
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic       part_bits;
  logic [7:0] status_snap;
  logic       deep_snap;

  modport link_end
  (
    output rx_byte,
    output rx_tgl,
    output part_bits,
    input  status_snap,
    input  deep_snap
  );

  modport core_end
  (
    input  rx_byte,
    input  rx_tgl,
    input  part_bits,
    output status_snap,
    output deep_snap
  );
endinterface

// file: serial_flash_spi_front_end.sv
`timescale 1ns/1ns
`include "spi_flash_cfg.svh"


module serial_flash_spi_front_end
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                sck_in,
  input  wire logic                cs_n_in,
  input  wire logic                si_in,
  input  wire logic                hold_n_in,
  input  wire logic                wp_n_in,
  output logic                     sdo_out,
  output logic                     sdo_oe_out,
  output logic [17:0]              arr_addr_out,
  output spi_flash_pkg::byte_type  arr_wdata_out,
  output logic                     arr_we_out,
  input  wire spi_flash_pkg::byte_type arr_rdata_in,
  output logic                     active_out,
  output logic                     deep_down_out
);
  import spi_flash_pkg::*;

  link_carrier_if ch ();

  spi_link_engine u_link
  (
    .ch         (ch.link_end),
    .rst_in     (rst_in),
    .sck_in     (sck_in),
    .cs_n_in    (cs_n_in),
    .si_in      (si_in),
    .hold_n_in  (hold_n_in),
    .sdo_out    (sdo_out),
    .sdo_oe_out (sdo_oe_out)
  );

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic sector_guarded(input logic [1:0] prot, input logic [1:0] sector);
    case (prot)
      2'h0:    sector_guarded = 1'b0;
      2'h1:    sector_guarded = (sector == 2'h3);
      2'h2:    sector_guarded = sector[1];
      default: sector_guarded = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0]     cs_sync_q;
  logic [1:0]     wp_sync_q;
  logic [2:0]     tgl_sync_q;
  logic [1:0]     part_sync_q;
  logic           cs_seen_q;
  logic           frame_begin;
  logic           frame_end;
  logic           byte_evt;
  logic           aligned;
  logic           frame_ok_q;
  logic [2:0]     nbytes_q;
  byte_type       cmd_q;
  logic [17:0]    addr_q;
  byte_type       sr_data_q;
  logic [7:0]     col_q;
  logic [255:0]   loaded_q;
  byte_type       page_buf [0:255];
  logic           cap_data;
  logic           latch_q;
  logic [1:0]     prot_q;
  logic           lock_q;
  logic           deep_q;
  byte_type       snap_q;
  byte_type       status_word;
  walk_state_type walk_q;
  logic [17:0]    ptr_q;
  logic [17:0]    end_q;
  logic           busy;
  logic           walk_done;
  logic           go;
  logic           ex;
  logic           sr_frozen;
  logic           do_unlock;
  logic           do_lock;
  logic           do_srw;
  logic           do_sleep;
  logic           do_wake;
  logic           do_prog;
  logic           do_sect;
  logic           do_bulk;

  // ----------------------------------------------------------------
  // Crossings from the pins and the link domain
  // ----------------------------------------------------------------
  // Chip select is delayed one stage past the byte toggle so that the last
  // byte of a frame is always taken before the frame end is judged.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cs_sync_q   <= 4'h0;
      cs_seen_q   <= 1'b0;
      wp_sync_q   <= 2'h3;
      tgl_sync_q  <= 3'h0;
      part_sync_q <= 2'h0;
    end
    else
    begin
      cs_sync_q   <= {cs_sync_q[2:0], cs_n_in};
      cs_seen_q   <= cs_seen_q | cs_sync_q[1];
      wp_sync_q   <= {wp_sync_q[0], wp_n_in};
      tgl_sync_q  <= {tgl_sync_q[1:0], ch.rx_tgl};
      part_sync_q <= {part_sync_q[0], ch.part_bits};
    end
  end

  assign frame_begin = ~cs_sync_q[1] & cs_sync_q[2];
  assign frame_end   = cs_sync_q[2] & ~cs_sync_q[3];
  assign byte_evt    = tgl_sync_q[1] ^ tgl_sync_q[2];
  assign aligned     = ~part_sync_q[1];
  assign busy        = (walk_q != WALK_IDLE);

  // ----------------------------------------------------------------
  // Instruction capture
  // ----------------------------------------------------------------
  // A frame counts only if its chip select fall was seen while idle;
  // the synchroniser resets low so a frame open at reset never counts.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      frame_ok_q <= 1'b0;
    else if (frame_begin)
      frame_ok_q <= ~busy;
    else if (frame_end)
      frame_ok_q <= 1'b0;
  end

  assign cap_data = byte_evt & frame_ok_q & (nbytes_q >= `CNT_ADDR_DONE)
                    & (cmd_q == `OP_PAGE_WRITE);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nbytes_q  <= 3'h0;
      cmd_q     <= 8'h00;
      addr_q    <= 18'h0_0000;
      sr_data_q <= 8'h00;
      col_q     <= 8'h00;
      loaded_q  <= '0;
    end
    else if (frame_begin && !busy)
    begin
      nbytes_q <= 3'h0;
      loaded_q <= '0;
    end
    else if (byte_evt && frame_ok_q)
    begin
      if (nbytes_q != `CNT_HAS_DATA)
        nbytes_q <= nbytes_q + 3'h1;
      if (nbytes_q == 3'h0)
        cmd_q <= ch.rx_byte;
      if (nbytes_q == `CNT_OPC_ONLY)
        sr_data_q <= ch.rx_byte;
      if (nbytes_q != 3'h0 && nbytes_q < `CNT_ADDR_DONE)
        addr_q <= {addr_q[9:0], ch.rx_byte};
      if (nbytes_q == `CNT_ADDR_LAST)
        col_q <= ch.rx_byte;
      if (cap_data)
      begin
        loaded_q[col_q] <= 1'b1;
        col_q           <= col_q + 8'h01;
      end
    end
  end

  // Later bytes of an overlong page write overwrite earlier ones in place.
  always_ff @(posedge clk_in)
  begin
    if (cap_data)
      page_buf[col_q] <= ch.rx_byte;
  end

  // ----------------------------------------------------------------
  // Execution decode
  // ----------------------------------------------------------------
  assign go        = frame_end & frame_ok_q;
  assign ex        = go & aligned & ~deep_q;
  assign sr_frozen = lock_q & ~wp_sync_q[1];
  assign do_wake   = go & (cmd_q == `OP_WAKE_AND_ID);
  assign do_unlock = ex & (cmd_q == `OP_WRITE_UNLOCK) & (nbytes_q == `CNT_OPC_ONLY);
  assign do_lock   = ex & (cmd_q == `OP_WRITE_LOCK) & (nbytes_q == `CNT_OPC_ONLY);
  assign do_sleep  = ex & (cmd_q == `OP_SLEEP) & (nbytes_q == `CNT_OPC_ONLY);
  assign do_srw    = ex & (cmd_q == `OP_STATUS_WRITE) & (nbytes_q >= `CNT_SR_DATA)
                     & latch_q & ~sr_frozen;
  assign do_prog   = ex & (cmd_q == `OP_PAGE_WRITE) & (nbytes_q == `CNT_HAS_DATA)
                     & latch_q & ~sector_guarded(prot_q, addr_q[17:16]);
  assign do_sect   = ex & (cmd_q == `OP_BLOCK_WIPE) & (nbytes_q == `CNT_ADDR_DONE)
                     & latch_q & ~sector_guarded(prot_q, addr_q[17:16]);
  assign do_bulk   = ex & (cmd_q == `OP_CHIP_WIPE) & (nbytes_q == `CNT_OPC_ONLY)
                     & latch_q & (prot_q == 2'h0);

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      latch_q <= 1'b0;
    else if (do_unlock)
      latch_q <= 1'b1;
    else if (do_lock || walk_done)
      latch_q <= 1'b0;
  end

  // Protect and lock bits have no backing store here, so reset reloads them.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prot_q <= `SR_PROTECT_RST;
      lock_q <= `SR_LOCK_RST;
    end
    else if (do_srw)
    begin
      prot_q <= {sr_data_q[`SR_PROT_HI_BIT], sr_data_q[`SR_PROT_LO_BIT]};
      lock_q <= sr_data_q[`SR_LOCK_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      deep_q <= 1'b0;
    else if (do_sleep)
      deep_q <= 1'b1;
    else if (do_wake)
      deep_q <= 1'b0;
  end

  always_comb
  begin
    status_word                  = 8'h00;
    status_word[`SR_BUSY_BIT]    = busy;
    status_word[`SR_LATCH_BIT]   = latch_q;
    status_word[`SR_PROT_LO_BIT] = prot_q[0];
    status_word[`SR_PROT_HI_BIT] = prot_q[1];
    status_word[`SR_LOCK_BIT]    = lock_q;
  end

  // The link reads this copy during a frame, so it only moves while deselected.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      snap_q <= 8'h00;
    else if (cs_sync_q[1])
      snap_q <= status_word;
  end

  assign ch.status_snap = snap_q;
  assign ch.deep_snap   = deep_q;

  // ----------------------------------------------------------------
  // Internal cycles
  // ----------------------------------------------------------------
  always_comb
  begin
    case (walk_q)
      WALK_PROG_RD: walk_done = ~loaded_q[ptr_q[7:0]] & (ptr_q[7:0] == `COL_LAST);
      WALK_PROG_WR: walk_done = (ptr_q[7:0] == `COL_LAST);
      WALK_ERASE:   walk_done = (ptr_q == end_q);
      WALK_SR_WAIT: walk_done = (ptr_q == 18'h0_0000);
      default:      walk_done = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      walk_q        <= WALK_IDLE;
      ptr_q         <= 18'h0_0000;
      end_q         <= 18'h0_0000;
      arr_addr_out  <= 18'h0_0000;
      arr_wdata_out <= 8'h00;
      arr_we_out    <= 1'b0;
    end
    else
    begin
      arr_we_out <= 1'b0;
      case (walk_q)
        WALK_IDLE:
        begin
          if (do_prog)
          begin
            walk_q <= WALK_PROG_RD;
            ptr_q  <= {addr_q[17:8], 8'h00};
          end
          else if (do_sect)
          begin
            walk_q <= WALK_ERASE;
            ptr_q  <= {addr_q[17:16], 16'h0000};
            end_q  <= {addr_q[17:16], `SECTOR_LAST};
          end
          else if (do_bulk)
          begin
            walk_q <= WALK_ERASE;
            ptr_q  <= 18'h0_0000;
            end_q  <= `ARRAY_LAST;
          end
          else if (do_srw)
          begin
            walk_q <= WALK_SR_WAIT;
            ptr_q  <= `STATUS_WR_CYCLES;
          end
        end
        WALK_PROG_RD:
        begin
          if (loaded_q[ptr_q[7:0]])
          begin
            arr_addr_out <= ptr_q;
            walk_q       <= WALK_PROG_WR;
          end
          else if (walk_done)
            walk_q <= WALK_IDLE;
          else
            ptr_q <= ptr_q + 18'h0_0001;
        end
        WALK_PROG_WR:
        begin
          arr_we_out    <= 1'b1;
          arr_wdata_out <= arr_rdata_in & page_buf[ptr_q[7:0]];
          walk_q        <= walk_done ? WALK_IDLE : WALK_PROG_RD;
          ptr_q         <= ptr_q + 18'h0_0001;
        end
        WALK_ERASE:
        begin
          arr_addr_out  <= ptr_q;
          arr_wdata_out <= `ERASE_FILL;
          arr_we_out    <= 1'b1;
          if (walk_done)
            walk_q <= WALK_IDLE;
          else
            ptr_q <= ptr_q + 18'h0_0001;
        end
        WALK_SR_WAIT:
        begin
          if (walk_done)
            walk_q <= WALK_IDLE;
          else
            ptr_q <= ptr_q - 18'h0_0001;
        end
        default:
          walk_q <= WALK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      active_out    <= 1'b0;
      deep_down_out <= 1'b0;
    end
    else
    begin
      // The select chain resets low, so selection counts only once a high level came through.
      active_out    <= (~cs_sync_q[1] & cs_seen_q) | busy;
      deep_down_out <= deep_q;
    end
  end

endmodule // serial_flash_spi_front_end

// file: serial_flash_spi_front_end_properties.sv
`timescale 1ns/1ns

module flash_port_checker
(
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic                    sck_in,
  input wire logic                    cs_n_in,
  input wire logic                    hold_n_in,
  input wire logic                    sdo_out,
  input wire logic                    sdo_oe_out,
  input wire logic [17:0]             arr_addr_out,
  input wire spi_flash_pkg::byte_type arr_wdata_out,
  input wire logic                    arr_we_out,
  input wire spi_flash_pkg::byte_type arr_rdata_in,
  input wire logic                    active_out,
  input wire logic                    deep_down_out
);
  import spi_flash_pkg::*;
  logic sdo_rise_q;
  logic rise_seen_q;

  // The first falling edge of a frame has no rising edge before it to compare with.
  always_ff @(posedge sck_in or posedge cs_n_in)
    if (cs_n_in)
      rise_seen_q <= 1'b0;
    else
      rise_seen_q <= 1'b1;

  always_ff @(posedge sck_in)
    sdo_rise_q <= sdo_out;

  chk_oe_deselect:
  assert property (@(posedge clk_in) disable iff (rst_in) cs_n_in |-> !sdo_oe_out)
    else $error("output driven while deselected");
  chk_sdo_fall_only:
  assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
    rise_seen_q |-> sdo_out == sdo_rise_q) else $error("output moved while clock high");
  chk_hold_floats:
  assert property (@(posedge sck_in) disable iff (rst_in)
    !hold_n_in && !$past(hold_n_in) |-> !sdo_oe_out) else $error("output driven in hold");
  chk_select_active:
  assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(cs_n_in) |-> ##[1:5] active_out) else $error("no active power when selected");
  chk_write_active:
  assert property (@(posedge clk_in) disable iff (rst_in) arr_we_out |-> active_out)
    else $error("array written in standby");
  chk_sleep_no_write:
  assert property (@(posedge clk_in) disable iff (rst_in) deep_down_out |-> !arr_we_out)
    else $error("array written in deep power-down");
  chk_sleep_stays:
  assert property (@(posedge clk_in) disable iff (rst_in)
    deep_down_out && !cs_n_in |=> deep_down_out) else $error("left sleep while selected");
  chk_clear_only:
  assert property (@(posedge clk_in) disable iff (rst_in) arr_we_out |->
    arr_wdata_out == 8'hff || (arr_wdata_out & ~arr_rdata_in) == 8'h00)
    else $error("program set a bit");
  chk_erase_sweep:
  assert property (@(posedge clk_in) disable iff (rst_in) arr_we_out ##1 arr_we_out
    |-> arr_addr_out == $past(arr_addr_out) + 18'h0_0001) else $error("erase skipped");

  cover property (@(posedge clk_in) arr_we_out && arr_wdata_out != 8'hff);
  cover property (@(posedge clk_in) $rose(deep_down_out));
  cover property (@(posedge clk_in) sdo_oe_out);
endmodule // flash_port_checker

bind serial_flash_spi_front_end flash_port_checker chk
(
  .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
  .hold_n_in(hold_n_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .arr_addr_out(arr_addr_out), .arr_wdata_out(arr_wdata_out), .arr_we_out(arr_we_out),
  .arr_rdata_in(arr_rdata_in), .active_out(active_out), .deep_down_out(deep_down_out)
);

// file: spi_flash_cfg.svh
`ifndef SPI_FLASH_CFG_SVH
`define SPI_FLASH_CFG_SVH

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define OP_WRITE_UNLOCK 8'h06
`define OP_WRITE_LOCK   8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_WRITE   8'h02
`define OP_BLOCK_WIPE   8'hd8
`define OP_CHIP_WIPE    8'hc7
`define OP_SLEEP        8'hb9
`define OP_WAKE_AND_ID  8'hab

// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define SR_BUSY_BIT     0
`define SR_LATCH_BIT    1
`define SR_PROT_LO_BIT  2
`define SR_PROT_HI_BIT  3
`define SR_LOCK_BIT     7
`define SR_PROTECT_RST  2'h0
`define SR_LOCK_RST     1'h0

// ----------------------------------------------------------------
// Byte counts within a frame, array geometry, timing
// ----------------------------------------------------------------
`define CNT_OPC_ONLY    3'h1
`define CNT_SR_DATA     3'h2
`define CNT_ADDR_LAST   3'h3
`define CNT_ADDR_DONE   3'h4
`define CNT_HAS_DATA    3'h5
`define CNT_SIG_START   3'h4
`define ERASE_FILL      8'hff
`define COL_LAST        8'hff
`define SECTOR_LAST     16'hffff
`define ARRAY_LAST      18'h3_ffff
`define STATUS_WR_CYCLES 18'h0_0010
// Arbitrary neutral identification value.
`define SIGNATURE_CODE  8'h5a

`endif

// file: spi_flash_pkg.sv
package spi_flash_pkg;

  typedef logic [7:0] byte_type;

  typedef enum logic [4:0]
  {
    WALK_IDLE    = 5'b00001,
    WALK_PROG_RD = 5'b00010,
    WALK_PROG_WR = 5'b00100,
    WALK_ERASE   = 5'b01000,
    WALK_SR_WAIT = 5'b10000
  } walk_state_type;

endpackage

// file: spi_link_engine.sv
`timescale 1ns/1ns
`include "spi_flash_cfg.svh"

module spi_link_engine
(
  link_carrier_if.link_end ch,
  input  wire logic        rst_in,
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        si_in,
  input  wire logic        hold_n_in,
  output logic             sdo_out,
  output logic             sdo_oe_out
);
  import spi_flash_pkg::*;

  logic       frame_rst;
  logic       frame_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  byte_type   rx_byte_q;
  logic       rx_tgl_q;
  logic [2:0] byte_cnt_q;
  byte_type   opc_q;
  byte_type   tx_sh_q;
  logic       tx_on_q;
  logic       run;
  logic       byte_done;
  logic       src_ok;
  byte_type   src_byte;

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  // Chip select high clears the frame state, so a hold cannot outlive it.
  assign frame_rst = rst_in | cs_n_in;
  assign run       = hold_n_in & ~cs_n_in;
  assign byte_done = run & frame_q & (bit_cnt_q == 3'h7);

  always_ff @(posedge sck_in or posedge frame_rst)
  begin
    if (frame_rst)
      frame_q <= 1'b0;
    else if (run)
      frame_q <= 1'b1;
  end

  // The bit counter survives deselection so the core can judge alignment.
  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
      bit_cnt_q <= 3'h0;
    else if (run)
      bit_cnt_q <= frame_q ? bit_cnt_q + 3'h1 : 3'h1;
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_sh_q   <= 7'h00;
      rx_byte_q <= 8'h00;
      rx_tgl_q  <= 1'b0;
    end
    else if (run)
    begin
      rx_sh_q <= {rx_sh_q[5:0], si_in};
      if (byte_done)
      begin
        rx_byte_q <= {rx_sh_q, si_in};
        rx_tgl_q  <= ~rx_tgl_q;
      end
    end
  end

  always_ff @(posedge sck_in or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      byte_cnt_q <= 3'h0;
      opc_q      <= 8'h00;
    end
    else if (byte_done)
    begin
      if (byte_cnt_q == 3'h0)
        opc_q <= {rx_sh_q, si_in};
      if (byte_cnt_q != 3'h7)
        byte_cnt_q <= byte_cnt_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  // The status copy is refreshed only between frames, so a long status
  // poll inside one frame repeats the value seen at its start.
  always_comb
  begin
    src_ok   = 1'b0;
    src_byte = 8'h00;
    if (byte_cnt_q != 3'h0 && opc_q == `OP_STATUS_READ && !ch.deep_snap)
    begin
      src_ok   = 1'b1;
      src_byte = ch.status_snap;
    end
    else if (byte_cnt_q >= `CNT_SIG_START && opc_q == `OP_WAKE_AND_ID)
    begin
      src_ok   = 1'b1;
      src_byte = `SIGNATURE_CODE;
    end
  end

  always_ff @(negedge sck_in or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
      tx_sh_q    <= 8'h00;
      tx_on_q    <= 1'b0;
    end
    else if (!hold_n_in)
      sdo_oe_out <= 1'b0;
    else if (frame_q && bit_cnt_q == 3'h0)
    begin
      tx_on_q    <= src_ok;
      sdo_oe_out <= src_ok;
      sdo_out    <= src_byte[7];
      tx_sh_q    <= {src_byte[6:0], 1'b0};
    end
    else
    begin
      sdo_oe_out <= tx_on_q;
      sdo_out    <= tx_sh_q[7];
      tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
    end
  end

  assign ch.rx_byte   = rx_byte_q;
  assign ch.rx_tgl    = rx_tgl_q;
  assign ch.part_bits = (bit_cnt_q != 3'h0);

endmodule // spi_link_engine

// file: spi_master_model.sv
`timescale 1ns/1ns

module spi_master_model
(
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      hold_n_out
);
  import spi_flash_pkg::*;
  byte_type tx_q[$];
  byte_type rx_q[$];
  logic     cpol    = 1'b0;
  int       hold_at = 0;
  logic     line_q  = 1'b0;

  initial
  begin
    sck_out    = 1'b0;
    cs_n_out   = 1'b1;
    si_out     = 1'b0;
    hold_n_out = 1'b1;
  end

  // Hold only with the clock low and chip select kept low.
  task automatic pause();
    sck_out = 1'b0;
    #4 hold_n_out = 1'b0;
    repeat (3)
    begin
      si_out = ~si_out;
      #8 sck_out = 1'b1;
      #7 sck_out = 1'b0;
    end
    #4 hold_n_out = 1'b1;
  endtask

  // A released line reads as the inverse of its last level, never as a kind constant.
  task automatic xfer(input int extra);
    int       n;
    byte_type b;
    n = 8 * tx_q.size() + extra;
    rx_q = {};
    @(posedge clk_in) #1;
    // The idle level settles before select falls, so no clock edge meets the select change.
    sck_out = cpol;
    #4 cs_n_out = 1'b0;
    #4;
    for (int i = 0; i < n; i++)
    begin
      if (i == hold_at && i > 0)
        pause();
      sck_out = 1'b0;
      si_out = (i < 8 * tx_q.size()) ? tx_q[i / 8][7 - (i % 8)] : 1'b0;
      #8 sck_out = 1'b1;
      line_q = sdo_oe_in ? sdo_in : ~line_q;
      b = {b[6:0], line_q};
      if (i % 8 == 7)
        rx_q.push_back(b);
      #7;
    end
    sck_out = cpol;
    #4 cs_n_out = 1'b1;
    repeat (10) @(posedge clk_in);
  endtask
endmodule // spi_master_model

// file: test_serial_flash_spi_front_end.sv
`timescale 1ns/1ns
`include "spi_flash_cfg.svh"

module test_serial_flash_spi_front_end;
  import spi_flash_pkg::*;
  logic        clk_in, rst_in, wp_n_in, sck, cs_n, si, hold_n, sdo, sdo_oe, we, active, deep;
  logic [17:0] addr;
  byte_type    wdata, rdata, st;
  byte_type    mem [0:262143];
  int          mismatches      = 0;
  int          samples_checked = 0;

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  assign rdata = mem[addr];
  always @(posedge clk_in)
    if (we)
      mem[addr] <= wdata;

  serial_flash_spi_front_end dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .hold_n_in(hold_n), .wp_n_in(wp_n_in), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .arr_addr_out(addr), .arr_wdata_out(wdata), .arr_we_out(we), .arr_rdata_in(rdata),
    .active_out(active), .deep_down_out(deep)
  );
  spi_master_model master
  (
    .clk_in(clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .sck_out(sck), .cs_n_out(cs_n),
    .si_out(si), .hold_n_out(hold_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input byte_type got, input byte_type exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input byte_type b[$], input int extra = 0);
    master.tx_q = b;
    master.xfer(extra);
  endtask

  task automatic rd_status();
    send({`OP_STATUS_READ, 8'h00});
    st = master.rx_q[1];
  endtask

  // Each poll is its own frame, since the status copy only refreshes between frames.
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      rd_status();
      n++;
    end
    while (st[0] !== 1'b0 && n < 5000);
    if (st[0] !== 1'b0)
    begin
      mismatches++;
      print_verdict();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_status();
    rd_status();
    check(st, 8'h00);
    send({`OP_WRITE_UNLOCK}, 1);
    rd_status();
    check(st, 8'h00);
    send({`OP_WRITE_UNLOCK});
    master.cpol = 1'b1;
    master.hold_at = 4;
    rd_status();
    check(st, 8'h02);
    master.cpol = 1'b0;
    master.hold_at = 0;
    send({`OP_WRITE_LOCK});
    rd_status();
    check(st, 8'h00);
  endtask

  task automatic t_program();
    mem[18'h0_1201] = 8'h96;
    send({`OP_PAGE_WRITE, 8'h00, 8'h12, 8'hfe, 8'h00});
    send({`OP_WRITE_UNLOCK});
    send({`OP_PAGE_WRITE, 8'h00, 8'h12, 8'hfe, 8'h0f, 8'hf0, 8'h3c, 8'ha5});
    wait_idle();
    check(st, 8'h00);
    check(mem[18'h0_12fe], 8'h0f);
    check(mem[18'h0_12ff], 8'hf0);
    check(mem[18'h0_1200], 8'h3c);
    check(mem[18'h0_1201], 8'h84);
    check(mem[18'h0_1300], 8'hff);
  endtask

  task automatic t_protect();
    send({`OP_WRITE_UNLOCK});
    send({`OP_STATUS_WRITE, 8'h84});
    wait_idle();
    check(st, 8'h84);
    @(posedge clk_in) #1 wp_n_in = 1'b0;
    send({`OP_WRITE_UNLOCK});
    send({`OP_STATUS_WRITE, 8'h00});
    wait_idle();
    check(st, 8'h86);
    send({`OP_PAGE_WRITE, 8'h03, 8'h00, 8'h00, 8'h00});
    send({`OP_CHIP_WIPE});
    rd_status();
    check(st, 8'h86);
    check(mem[18'h3_0000], 8'hff);
    @(posedge clk_in) #1 wp_n_in = 1'b1;
    send({`OP_STATUS_WRITE, 8'h00});
    wait_idle();
    check(st, 8'h00);
  endtask

  task automatic t_erase();
    mem[18'h1_0000] = 8'h00;
    mem[18'h1_ffff] = 8'h00;
    mem[18'h0_ffff] = 8'h00;
    send({`OP_BLOCK_WIPE, 8'h01, 8'h23, 8'h45});
    rd_status();
    check(st, 8'h00);
    send({`OP_WRITE_UNLOCK});
    send({`OP_BLOCK_WIPE, 8'h01, 8'h23, 8'h45});
    rd_status();
    check(st, 8'h03);
    check({7'h00, active}, 8'h01);
    wait_idle();
    check(st, 8'h00);
    check({7'h00, active}, 8'h00);
    check(mem[18'h1_0000], 8'hff);
    check(mem[18'h1_ffff], 8'hff);
    check(mem[18'h0_ffff], 8'h00);
  endtask

  task automatic t_sleep();
    send({`OP_SLEEP});
    check({7'h00, deep}, 8'h01);
    send({`OP_WRITE_UNLOCK});
    rd_status();
    check({7'h00, deep}, 8'h01);
    send({`OP_WAKE_AND_ID, 8'h00, 8'h00, 8'h00, 8'h00});
    check(master.rx_q[4], `SIGNATURE_CODE);
    check({7'h00, deep}, 8'h00);
    rd_status();
    check(st, 8'h00);
  endtask

  initial
  begin
    rst_in = 1'b1;
    wp_n_in = 1'b1;
    for (int i = 0; i < 262144; i++)
      mem[i] = 8'hff;
    repeat (10) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    t_status();
    t_program();
    t_protect();
    t_erase();
    t_sleep();
    print_verdict();
  end
endmodule // test_serial_flash_spi_front_end
